// ===== design/rls_pkg.sv
// shared constants, carriers and states for the receive link host controller
package rls_pkg;

    // system clock: 250 MHz, 4 ns period
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CLK_FREQ_KHZ = 250000;

    // allowed register port clock range
    localparam int REG_CLK_MIN_KHZ = 75000;
    localparam int REG_CLK_MAX_KHZ = 125000;

    // i_clk cycles per half period of the register port clock
    localparam int REG_CLK_HALF_CYC = 1;

    // register port widths: word address and data
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;

    // stream layout: one big-endian 32-bit word per lane
    localparam int OCTET_W = 8;
    localparam int LANE_W = 32;
    localparam int DEFAULT_LANES = 1;

    // depth of the beat buffer in the receive path
    localparam int BEAT_BUF_DEPTH = 2;

    // flip-flops on every pin input
    localparam int SYNC_STAGES = 2;

    // least hold times for the two resets, in ns
    localparam int REG_RST_HOLD_NS = 100;
    localparam int XCVR_RST_HOLD_NS = 1000;

    // round a least time in ns up to whole clock cycles, never below one
    function automatic int ns_to_cyc_up(input int ns);
        int cyc;
        cyc = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    localparam int REG_RST_HOLD_CYC = ns_to_cyc_up(REG_RST_HOLD_NS);
    localparam int XCVR_RST_HOLD_CYC = ns_to_cyc_up(XCVR_RST_HOLD_NS);

    // one register access requested by user logic
    typedef struct packed {
        logic write;
        logic [REG_ADDR_W-1:0] addr;
        logic [REG_DATA_W-1:0] wdata;
    } rls_cmd_t;

    // register port pins driven toward the device
    typedef struct packed {
        logic select;
        logic rd_strobe;
        logic wr_strobe;
        logic [REG_ADDR_W-1:0] word_addr;
        logic [REG_DATA_W-1:0] wdata;
    } rls_reg_pins_t;

    // answer to one register access
    typedef struct packed {
        logic write;
        logic [REG_DATA_W-1:0] rdata;
    } rls_rsp_t;

    // register access sequencer
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LAUNCH = 3'b001,
        ST_ACCESS = 3'b010,
        ST_SAMPLE = 3'b011,
        ST_RESPOND = 3'b100
    } rls_state_t;

endpackage

// ===== design/rls_reg_clkgen.sv
// register port clock divider with edge-ahead pulses
`timescale 1ns/1ps

module rls_reg_clkgen #(
    parameter int HALF_CYC = rls_pkg::REG_CLK_HALF_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    output logic o_reg_clk,
    output logic o_rise,
    output logic o_fall
);

    localparam int CNT_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);
    localparam int REG_CLK_KHZ = rls_pkg::CLK_FREQ_KHZ / (2 * HALF_CYC);

    // refuse dividers that leave the allowed clock range
    initial begin
        if (HALF_CYC < 1 || REG_CLK_KHZ < rls_pkg::REG_CLK_MIN_KHZ || REG_CLK_KHZ > rls_pkg::REG_CLK_MAX_KHZ) begin
            $error("rls_reg_clkgen: divider gives a register clock out of range");
        end
    end

    logic [CNT_W-1:0] cnt;
    logic last;

    assign last = (cnt == CNT_LAST);
    // high in the cycle whose closing edge raises or lowers the clock
    assign o_rise = last & ~o_reg_clk;
    assign o_fall = last & o_reg_clk;

    // half-period counter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= '0;
        end else if (last) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    // clock output toggles at the end of each half period
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_clk <= 1'b0;
        end else if (last) begin
            o_reg_clk <= ~o_reg_clk;
        end
    end

endmodule

// ===== design/rls_beat_buf.sv
// small shift buffer for stream beats, head entry is the output register
`timescale 1ns/1ps

module rls_beat_buf #(
    parameter int WIDTH = rls_pkg::LANE_W,
    parameter int DEPTH = rls_pkg::BEAT_BUF_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);

    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("rls_beat_buf: needs at least two entries and one bit");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [CNT_W-1:0] count;
    logic push;
    logic pop;
    logic [CNT_W-1:0] wr_idx;

    assign o_in_ready = (count != CNT_FULL);
    assign o_out_data = mem[0];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    // a pop frees the slot below the write point in the same cycle
    assign wr_idx = pop ? count - CNT_W'(1) : count;

    // occupancy
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + CNT_W'(1);
        end else if (pop && !push) begin
            count <= count - CNT_W'(1);
        end
    end

    // head-valid flag held in its own flop so the output carries no logic
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_out_valid <= 1'b0;
        end else if (push && !pop) begin
            o_out_valid <= 1'b1;
        end else if (pop && !push) begin
            o_out_valid <= (count != CNT_W'(1));
        end
    end

    // storage shifts toward the head on a pop, new beat lands behind the last
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && CNT_W'(i) == wr_idx) begin
                    mem[i] <= i_in_data;
                end else if (pop && i < DEPTH - 1) begin
                    mem[i] <= mem[i+1];
                end
            end
        end
    end

endmodule

// ===== design/rls_host_ctrl.sv
// host controller for the receive link stream and its register port
`timescale 1ns/1ps

module rls_host_ctrl #(
    parameter int LANES = rls_pkg::DEFAULT_LANES,
    parameter int REG_HALF_CYC = rls_pkg::REG_CLK_HALF_CYC,
    parameter int BUF_DEPTH = rls_pkg::BEAT_BUF_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cmd_valid,
    input wire rls_pkg::rls_cmd_t i_cmd,
    output logic o_cmd_ready,
    output logic o_rsp_valid,
    output rls_pkg::rls_rsp_t o_rsp,
    output logic o_reg_port_clock,
    output logic o_reg_port_reset_low,
    output rls_pkg::rls_reg_pins_t o_reg_pins,
    input wire logic [rls_pkg::REG_DATA_W-1:0] i_reg_port_rdata,
    input wire logic i_reg_port_stall,
    input wire logic [LANES*rls_pkg::LANE_W-1:0] i_rx_lane_octets_out,
    input wire logic i_rx_stream_valid,
    output logic o_transport_sink_ready,
    output logic o_transport_frame_error,
    output logic o_beat_valid,
    output logic [LANES*rls_pkg::LANE_W-1:0] o_beat_data,
    input wire logic i_beat_ready,
    output logic o_overflow_seen,
    input wire logic i_overflow_clr,
    input wire logic i_xcvr_reset_req,
    output logic o_xcvr_rx_hard_reset
);

    localparam int BEAT_W = LANES * rls_pkg::LANE_W;
    localparam int RST_CNT_W = $clog2(rls_pkg::REG_RST_HOLD_CYC + 1);
    localparam logic [RST_CNT_W-1:0] RST_CNT_DONE = RST_CNT_W'(rls_pkg::REG_RST_HOLD_CYC);
    localparam int XRST_CNT_W = $clog2(rls_pkg::XCVR_RST_HOLD_CYC + 1);
    localparam logic [XRST_CNT_W-1:0] XRST_CNT_LAST = XRST_CNT_W'(rls_pkg::XCVR_RST_HOLD_CYC - 1);
    localparam logic [1:0] SMP_LAST = 2'(rls_pkg::SYNC_STAGES - 1);

    initial begin
        if (LANES < 1 || LANES > 8) begin
            $error("rls_host_ctrl: lane count must be 1 to 8");
        end
        if (rls_pkg::SYNC_STAGES != 2) begin
            $error("rls_host_ctrl: sampler is built for two stages");
        end
    end

    rls_pkg::rls_state_t state;
    rls_pkg::rls_state_t next_state;
    rls_pkg::rls_cmd_t cmd;
    logic reg_clk_rise;
    logic reg_clk_fall;
    logic accept;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [1:0] smp_cnt;
    logic [rls_pkg::REG_DATA_W-1:0] rdata_s1;
    logic [rls_pkg::REG_DATA_W-1:0] rdata_s2;
    logic stall_s1;
    logic stall_s2;
    logic buf_in_ready;
    logic beat_lost;
    logic [XRST_CNT_W-1:0] xrst_cnt;

    rls_reg_clkgen #(
        .HALF_CYC(REG_HALF_CYC)
    ) u_clkgen (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .o_reg_clk(o_reg_port_clock),
        .o_rise(reg_clk_rise),
        .o_fall(reg_clk_fall)
    );

    // ---------------- register port reset ----------------

    // hold time counter after the system reset lets go
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_cnt <= '0;
        end else if (rst_cnt != RST_CNT_DONE) begin
            rst_cnt <= rst_cnt + RST_CNT_W'(1);
        end
    end

    // async assert, release on a falling register clock edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_port_reset_low <= 1'b0;
        end else if (rst_cnt == RST_CNT_DONE && reg_clk_fall) begin
            o_reg_port_reset_low <= 1'b1;
        end
    end

    // ---------------- register access sequencer ----------------

    assign accept = i_cmd_valid & o_cmd_ready;

    // next state of the access sequencer
    always_comb begin
        next_state = state;
        case (state)
            rls_pkg::ST_IDLE: begin
                if (accept) begin
                    next_state = rls_pkg::ST_LAUNCH;
                end
            end
            rls_pkg::ST_LAUNCH: begin
                if (reg_clk_fall) begin
                    next_state = rls_pkg::ST_ACCESS;
                end
            end
            rls_pkg::ST_ACCESS: begin
                if (reg_clk_rise) begin
                    next_state = rls_pkg::ST_SAMPLE;
                end
            end
            rls_pkg::ST_SAMPLE: begin
                // a stalled access is issued again
                if (smp_cnt == SMP_LAST) begin
                    next_state = stall_s2 ? rls_pkg::ST_LAUNCH : rls_pkg::ST_RESPOND;
                end
            end
            rls_pkg::ST_RESPOND: begin
                next_state = rls_pkg::ST_IDLE;
            end
            default: begin
                next_state = rls_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= rls_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // commands are taken only once the register reset is released
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cmd_ready <= 1'b0;
        end else begin
            o_cmd_ready <= o_reg_port_reset_low && next_state == rls_pkg::ST_IDLE;
        end
    end

    // latched command
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd <= '0;
        end else if (accept) begin
            cmd <= i_cmd;
        end
    end

    // cycles spent waiting for the pin samplers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            smp_cnt <= '0;
        end else if (state == rls_pkg::ST_SAMPLE) begin
            smp_cnt <= smp_cnt + 2'h1;
        end else begin
            smp_cnt <= '0;
        end
    end

    // pins change only on falling register clock edges, away from the sampling edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_pins <= '0;
        end else if (reg_clk_fall) begin
            if (state == rls_pkg::ST_LAUNCH) begin
                // chip select goes up together with the strobe
                o_reg_pins.select <= 1'b1;
                o_reg_pins.rd_strobe <= ~cmd.write;
                o_reg_pins.wr_strobe <= cmd.write;
                o_reg_pins.word_addr <= cmd.addr;
                o_reg_pins.wdata <= cmd.wdata;
            end else if (state != rls_pkg::ST_ACCESS) begin
                o_reg_pins.select <= 1'b0;
                o_reg_pins.rd_strobe <= 1'b0;
                o_reg_pins.wr_strobe <= 1'b0;
            end
        end
    end

    // two-stage samplers on the read data and stall pins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_s1 <= '0;
            rdata_s2 <= '0;
            stall_s1 <= 1'b0;
            stall_s2 <= 1'b0;
        end else begin
            rdata_s1 <= i_reg_port_rdata;
            rdata_s2 <= rdata_s1;
            stall_s1 <= i_reg_port_stall;
            stall_s2 <= stall_s1;
        end
    end

    // answer carries the read data sampled at the access edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rsp_valid <= 1'b0;
            o_rsp <= '0;
        end else begin
            o_rsp_valid <= (state == rls_pkg::ST_SAMPLE && next_state == rls_pkg::ST_RESPOND);
            if (state == rls_pkg::ST_SAMPLE && next_state == rls_pkg::ST_RESPOND) begin
                o_rsp.write <= cmd.write;
                o_rsp.rdata <= cmd.write ? '0 : rdata_s2;
            end
        end
    end

    // ---------------- receive stream ----------------

    // every valid beat is offered, the buffer absorbs downstream stalls
    // lane words keep their big-endian octet order through the buffer
    rls_beat_buf #(
        .WIDTH(BEAT_W),
        .DEPTH(BUF_DEPTH)
    ) u_beat_buf (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_rx_stream_valid),
        .i_in_data(i_rx_lane_octets_out),
        .o_in_ready(buf_in_ready),
        .o_out_valid(o_beat_valid),
        .o_out_data(o_beat_data),
        .i_out_ready(i_beat_ready)
    );

    // a beat flagged valid with no room is lost
    assign beat_lost = i_rx_stream_valid & ~buf_in_ready;

    // ready shows room in the buffer
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_transport_sink_ready <= 1'b0;
        end else begin
            o_transport_sink_ready <= buf_in_ready;
        end
    end

    // frame error pulses for each lost beat
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_transport_frame_error <= 1'b0;
        end else begin
            o_transport_frame_error <= beat_lost;
        end
    end

    // sticky loss flag, a new loss wins over a clear
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_overflow_seen <= 1'b0;
        end else if (beat_lost) begin
            o_overflow_seen <= 1'b1;
        end else if (i_overflow_clr) begin
            o_overflow_seen <= 1'b0;
        end
    end

    // ---------------- transceiver hard reset ----------------

    // active-high pulse of least hold time after reset or on request
    // this does not reset the analog section; that goes through reconfiguration
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_xcvr_rx_hard_reset <= 1'b1;
            xrst_cnt <= '0;
        end else if (i_xcvr_reset_req) begin
            o_xcvr_rx_hard_reset <= 1'b1;
            xrst_cnt <= '0;
        end else if (o_xcvr_rx_hard_reset) begin
            if (xrst_cnt == XRST_CNT_LAST) begin
                o_xcvr_rx_hard_reset <= 1'b0;
            end else begin
                xrst_cnt <= xrst_cnt + XRST_CNT_W'(1);
            end
        end
    end

endmodule

// ===== verif/rls_host_ctrl_assertions.sv
// assertion checker for the receive link host controller ports
`timescale 1ns/1ps
module rls_host_ctrl_chk #(
    parameter int LANES = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cmd_valid,
    input wire rls_pkg::rls_cmd_t i_cmd,
    input wire logic o_cmd_ready,
    input wire logic o_rsp_valid,
    input wire rls_pkg::rls_rsp_t o_rsp,
    input wire logic o_reg_port_clock,
    input wire logic o_reg_port_reset_low,
    input wire rls_pkg::rls_reg_pins_t o_reg_pins,
    input wire logic [rls_pkg::REG_DATA_W-1:0] i_reg_port_rdata,
    input wire logic [LANES*rls_pkg::LANE_W-1:0] i_rx_lane_octets_out,
    input wire logic i_rx_stream_valid,
    input wire logic o_transport_frame_error,
    input wire logic o_beat_valid,
    input wire logic [LANES*rls_pkg::LANE_W-1:0] o_beat_data,
    input wire logic o_overflow_seen,
    input wire logic o_xcvr_rx_hard_reset
);
    logic [8:0] cyc;
    logic [31:0] cap;
    rls_pkg::rls_cmd_t last;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // cycles since reset release, saturating
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cyc <= 9'h000;
        end else if (cyc != 9'h1ff) begin
            cyc <= cyc + 9'h001;
        end
    end
    // last taken command and read data seen at the device sampling edge
    always_ff @(posedge i_clk) begin
        if (i_cmd_valid && o_cmd_ready) begin
            last <= i_cmd;
        end
        if (o_reg_pins.rd_strobe && !o_reg_port_clock) begin
            cap <= i_reg_port_rdata;
        end
    end
    AST_SEL_WITH_STROBE: assert property (o_reg_pins.select == (o_reg_pins.rd_strobe | o_reg_pins.wr_strobe))
        else $error("select differs from strobes");
    AST_NO_STROBE_IN_REG_RST: assert property (!o_reg_port_reset_low |-> !(o_reg_pins.rd_strobe | o_reg_pins.wr_strobe))
        else $error("strobe during register reset");
    AST_REG_RST_HOLD: assert property (cyc < 9'h019 |-> !o_reg_port_reset_low)
        else $error("register reset released too early");
    AST_REG_CLK_TOGGLE: assert property (cyc != 9'h000 |-> o_reg_port_clock != $past(o_reg_port_clock))
        else $error("register clock not toggling");
    AST_XCVR_RST_HOLD: assert property (cyc < 9'h0fa |-> o_xcvr_rx_hard_reset)
        else $error("hard reset released too early");
    AST_TAKE_TO_RSP: assert property (i_cmd_valid && o_cmd_ready |-> ##[4:6] o_rsp_valid)
        else $error("no answer in time");
    AST_RSP_PULSE: assert property (o_rsp_valid |=> !o_rsp_valid && o_cmd_ready)
        else $error("answer not a single pulse");
    AST_PINS_MATCH_CMD: assert property (o_reg_pins.select |->
        o_reg_pins.word_addr == last.addr && o_reg_pins.wr_strobe == last.write)
        else $error("pins differ from command");
    AST_WDATA_MATCH: assert property (o_reg_pins.wr_strobe |-> o_reg_pins.wdata == last.wdata)
        else $error("write data differs");
    AST_READ_DATA: assert property (o_rsp_valid && !o_rsp.write |-> o_rsp.rdata == cap)
        else $error("read answer differs from device data");
    AST_WRITE_RSP_ZERO: assert property (o_rsp_valid && o_rsp.write |-> o_rsp.rdata == 32'h0)
        else $error("write answer not zero");
    AST_BEAT_FIRST: assert property (i_rx_stream_valid && !o_beat_valid |=>
        o_beat_valid && o_beat_data == $past(i_rx_lane_octets_out))
        else $error("beat not presented");
    AST_LOSS_STICKY: assert property (o_transport_frame_error |-> o_overflow_seen)
        else $error("loss not flagged");
    COV_READ: cover property (o_rsp_valid && !o_rsp.write);
    COV_WRITE: cover property (o_rsp_valid && o_rsp.write);
    COV_LOSS: cover property (o_transport_frame_error);
endmodule

// ===== verif/rls_dev_model.sv
// device-side model: register slave and beat source
`timescale 1ns/1ps
module rls_dev_model #(
    parameter int LANES = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_clk,
    input wire logic i_reg_rst_b,
    input wire rls_pkg::rls_reg_pins_t i_pins,
    output logic [31:0] o_rdata,
    output logic o_stall,
    input wire logic i_send,
    input wire logic [LANES*32-1:0] i_word,
    output logic o_valid,
    output logic [LANES*32-1:0] o_data
);
    logic [31:0] mem [4];
    logic hit;
    assign hit = (i_pins.word_addr < 8'h04);
    assign o_stall = 1'b0;
    // read data while selected with the read strobe, toggling junk otherwise
    assign o_rdata = (i_pins.select && i_pins.rd_strobe) ? (hit ? mem[i_pins.word_addr[1:0]] : 32'h0)
        : ({32{i_clk}} ^ 32'h5a5a_5a5a);
    // writes land only when selected and mapped
    always_ff @(posedge i_reg_clk or negedge i_reg_rst_b) begin
        if (!i_reg_rst_b) begin
            for (int i = 0; i < 4; i++) mem[i] <= 32'h0;
        end else if (i_pins.select && i_pins.wr_strobe && hit) begin
            mem[i_pins.word_addr[1:0]] <= i_pins.wdata;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_valid <= 1'b0;
            o_data <= '0;
        end else begin
            o_valid <= i_send;
            o_data <= i_send ? i_word : ~o_data;
        end
    end
endmodule

// ===== verif/test_rls_host_ctrl.sv
// self-checking bench for the receive link host controller
`timescale 1ns/1ps
module test_rls_host_ctrl;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    rls_pkg::rls_cmd_t cmd = '0;
    rls_pkg::rls_rsp_t rsp;
    rls_pkg::rls_reg_pins_t pins;
    logic cmd_ready, rsp_valid, reg_clk, reg_rst_b, stall, dev_valid, sink_ready, frame_err;
    logic beat_valid, ovf, xcvr_rst;
    logic [31:0] rdata, dev_data, beat_data;
    logic beat_ready = 1'b0;
    logic ovf_clr = 1'b0;
    logic xcvr_req = 1'b0;
    logic send = 1'b0;
    logic [31:0] word = '0;
    logic [31:0] got [$];
    int miscompares = 0;
    int checked = 0;
    int errs = 0;
    // clock
    always #2 i_clk = ~i_clk;
    rls_host_ctrl rls_host_ctrl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_reg_port_clock(reg_clk),
        .o_reg_port_reset_low(reg_rst_b), .o_reg_pins(pins), .i_reg_port_rdata(rdata), .i_reg_port_stall(stall),
        .i_rx_lane_octets_out(dev_data), .i_rx_stream_valid(dev_valid), .o_transport_sink_ready(sink_ready),
        .o_transport_frame_error(frame_err), .o_beat_valid(beat_valid), .o_beat_data(beat_data),
        .i_beat_ready(beat_ready), .o_overflow_seen(ovf), .i_overflow_clr(ovf_clr),
        .i_xcvr_reset_req(xcvr_req), .o_xcvr_rx_hard_reset(xcvr_rst));
    rls_dev_model rls_dev_model_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_clk(reg_clk),
        .i_reg_rst_b(reg_rst_b), .i_pins(pins), .o_rdata(rdata), .o_stall(stall), .i_send(send),
        .i_word(word), .o_valid(dev_valid), .o_data(dev_data));
    // collect delivered beats and count losses
    always @(posedge i_clk) begin
        if (beat_valid === 1'b1 && beat_ready) got.push_back(beat_data);
        if (frame_err === 1'b1) errs++;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic timeout();
        miscompares++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        report_and_stop();
    endtask
    // one register access through the command port
    task automatic reg_access(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1) begin
            if (++n > 100) timeout();
            @(negedge i_clk);
        end
        cmd_valid = 1'b1;
        cmd = '{wr, addr, wd};
        @(negedge i_clk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1) begin
            if (++n > 8) timeout();
            @(negedge i_clk);
        end
        rd = rsp.rdata;
        check(rsp.write, wr);
        @(negedge i_clk);
        check({rsp_valid, cmd_ready}, 2'b01);
    endtask
    task automatic t_reset();
        int n;
        n = 0;
        check({reg_rst_b, pins.rd_strobe, pins.wr_strobe, xcvr_rst}, 4'h1);
        while (reg_rst_b !== 1'b1) begin
            if (++n > 40) timeout();
            @(negedge i_clk);
        end
        check(n >= 24 && n <= 30, 1'b1);
        while (xcvr_rst !== 1'b0) begin
            if (++n > 400) timeout();
            @(negedge i_clk);
        end
        check(n >= 248 && n <= 252, 1'b1);
        xcvr_req = 1'b1;
        @(negedge i_clk);
        xcvr_req = 1'b0;
        repeat (3) @(negedge i_clk);
        check(xcvr_rst, 1'b1);
        check(reg_rst_b, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_regs();
        logic [31:0] rd;
        for (int i = 0; i < 4; i++) reg_access(1'b1, 8'(i), 32'hc0de_0000 + 32'(i), rd);
        reg_access(1'b1, 8'h40, 32'hffff_ffff, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            reg_access(1'b0, 8'(i), 32'h0, rd);
            check(rd, 32'hc0de_0000 + 32'(i));
        end
        reg_access(1'b0, 8'h40, 32'h0, rd);
        check(rd, 32'h0);
        $display("test registers done");
    endtask
    // push beats from the device model back to back
    task automatic send_beats(input int cnt, input logic [31:0] base);
        for (int i = 0; i < cnt; i++) begin
            send = 1'b1;
            word = base + 32'(i);
            @(negedge i_clk);
        end
        send = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic t_stream();
        beat_ready = 1'b1;
        send_beats(4, 32'h0a0b_0c00);
        check(got.size(), 4);
        for (int i = 0; i < 4; i++) check(got[i], 32'h0a0b_0c00 + 32'(i));
        check(errs, 0);
        got.delete();
        beat_ready = 1'b0;
        send_beats(3, 32'h1122_3300);
        check({errs[1:0], ovf, sink_ready}, 4'h6);
        beat_ready = 1'b1;
        repeat (4) @(negedge i_clk);
        check(got.size(), 2);
        check({got[0], got[1]}, {32'h1122_3300, 32'h1122_3301});
        check(sink_ready, 1'b1);
        ovf_clr = 1'b1;
        @(negedge i_clk);
        ovf_clr = 1'b0;
        @(negedge i_clk);
        check(ovf, 1'b0);
        $display("test stream done");
    endtask
    // main sequence
    initial begin
        repeat (2) @(negedge i_clk);
        i_rst_b = 1'b1;
        t_reset();
        t_regs();
        t_stream();
        report_and_stop();
    end
endmodule
bind rls_host_ctrl rls_host_ctrl_chk #(.LANES(LANES)) rls_host_ctrl_chk_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
    .o_reg_port_clock(o_reg_port_clock), .o_reg_port_reset_low(o_reg_port_reset_low), .o_reg_pins(o_reg_pins),
    .i_reg_port_rdata(i_reg_port_rdata), .i_rx_lane_octets_out(i_rx_lane_octets_out),
    .i_rx_stream_valid(i_rx_stream_valid), .o_transport_frame_error(o_transport_frame_error),
    .o_beat_valid(o_beat_valid), .o_beat_data(o_beat_data), .o_overflow_seen(o_overflow_seen),
    .o_xcvr_rx_hard_reset(o_xcvr_rx_hard_reset));
